// ---- hw/adc_spi_config_access_status.v ----
// serial interface: register access decode, configuration register, status append
// Function
// - instruction is command byte plus data byte
// - first bit zero requests register access
// - second command bit selects write or read
// - bits five to zero must match pattern
// - capture serial input on rising clock
// - shift serial output on falling clock
// - convert start rise releases serial output
// - write data MSB first, update after byte
// - read shifts configuration out MSB first
// - no register reads in daisy chain
// - configuration bit zero is read only
// - write may share frame with result
// - status enable appends six status bits, except in register read frames
// - status MSB first right after LSB
// - release output after sixth status bit, except in daisy chain
// - short status readout still allows next conversion
// - status bits mirror clamp and the span, high-z and turbo enables
// - eight bit configuration register holds enables
// - enable bit positions, reset zero
// - clamp flag active low, sticky, cleared by read
`include "adc_cfg_regs.vh"
module adc_spi_config_access_status
#(
	parameter RESULT_W = `RESULT_BITS,
	parameter STATUS_W = `STATUS_BITS
)
(
	input wire core_clk,
	input wire reset_n,
	input wire convert_start,
	input wire sck,
	input wire serial_in,
	input wire [RESULT_W-1:0] conv_result,
	input wire overvoltage,
	input wire daisy_chain_mode,
	output reg serial_out_o,
	output reg serial_out_oe,
	output reg status_en,
	output reg span_en,
	output reg hiz_en,
	output reg turbo_en,
	output reg input_clamp_flag
);
	localparam ST_IDLE = 3'b001;
	localparam ST_CMD = 3'b010;
	localparam ST_DATA = 3'b100;
	reg rst_a_reg;
	reg rst_b_reg;
	wire rst_n;
	wire cs_lvl;
	wire sck_lvl;
	wire sdi_lvl;
	reg cs_d_reg;
	reg sck_d_reg;
	reg [2:0] state_reg;
	reg [4:0] bit_cnt_reg;
	reg [7:0] shift_in_reg;
	reg access_reg;
	reg read_reg;
	reg [7:0] cfg_reg;
	reg ov_seen_reg;
	reg [RESULT_W+STATUS_W-1:0] out_sh_reg;
	reg [4:0] out_cnt_reg;
	reg [4:0] out_len_reg;
	wire cs_fall;
	wire cs_rise;
	wire sck_rise;
	wire sck_fall;
	wire [7:0] cmd_word;
	wire [STATUS_W-1:0] status_word;
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_a_reg <= 1'b0;
			rst_b_reg <= 1'b0;
		end
		else
		begin
			rst_a_reg <= 1'b1;
			rst_b_reg <= rst_a_reg;
		end
	end
	assign rst_n = rst_b_reg;
	pin_sync u_cs
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin(convert_start),
		.level_reg(cs_lvl)
	);
	pin_sync u_sck
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin(sck),
		.level_reg(sck_lvl)
	);
	pin_sync u_sdi
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.pin(serial_in),
		.level_reg(sdi_lvl)
	);
	assign cs_fall = cs_d_reg & ~cs_lvl;
	assign cs_rise = ~cs_d_reg & cs_lvl;
	assign sck_rise = ~sck_d_reg & sck_lvl & ~cs_lvl;
	assign sck_fall = sck_d_reg & ~sck_lvl & ~cs_lvl;
	assign cmd_word = {shift_in_reg[6:0], sdi_lvl};
	// status: clamp, span, high-z, turbo, two reserved zeros
	assign status_word = {cfg_reg[`CFG_CLAMP], cfg_reg[`CFG_SPAN_EN], cfg_reg[`CFG_HIZ_EN],
		cfg_reg[`CFG_TURBO_EN], 2'b00};
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cs_d_reg <= 1'b1;
			sck_d_reg <= 1'b0;
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 5'h00;
			shift_in_reg <= 8'h00;
			access_reg <= 1'b0;
			read_reg <= 1'b0;
			cfg_reg <= `CFG_RESET;
			ov_seen_reg <= 1'b0;
			out_sh_reg <= {(RESULT_W+STATUS_W){1'b0}};
			out_cnt_reg <= 5'h00;
			out_len_reg <= 5'h00;
			serial_out_o <= 1'b0;
			serial_out_oe <= 1'b0;
		end
		else
		begin
			cs_d_reg <= cs_lvl;
			sck_d_reg <= sck_lvl;
			// clamp flag goes low on any overvoltage and stays low; the set wins over a read clear
			if (overvoltage)
			begin
				cfg_reg[`CFG_CLAMP] <= 1'b0;
				ov_seen_reg <= 1'b1;
			end
			if (cs_rise)
			begin
				state_reg <= ST_IDLE;
				serial_out_oe <= 1'b0;
				access_reg <= 1'b0;
			end
			else if (cs_fall)
			begin
				// frame opens with the result MSB; status appended when enabled
				// counters restart here, so a cut status readout never blocks the next frame
				state_reg <= ST_CMD;
				bit_cnt_reg <= 5'h00;
				access_reg <= 1'b0;
				read_reg <= 1'b0;
				out_sh_reg <= {conv_result, status_word};
				out_len_reg <= cfg_reg[`CFG_STATUS_EN] ? 5'd22 : 5'd16;
				out_cnt_reg <= 5'h01;
				serial_out_o <= conv_result[RESULT_W-1];
				serial_out_oe <= 1'b1;
			end
			else
			begin
				if (sck_rise && state_reg != ST_IDLE)
				begin
					shift_in_reg <= cmd_word;
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
					if (state_reg == ST_CMD && bit_cnt_reg == 5'd7)
					begin
						// first bit low, fixed pattern matched
						if (!cmd_word[7] && cmd_word[5:0] == `CMD_PATTERN)
						begin
							// a read in daisy chain is refused outright, so its data byte never writes
							access_reg <= ~(cmd_word[`CMD_RW_BIT] & daisy_chain_mode);
							read_reg <= cmd_word[`CMD_RW_BIT] & ~daisy_chain_mode;
							state_reg <= ST_DATA;
							if (cmd_word[`CMD_RW_BIT] && !daisy_chain_mode)
							begin
								// read replaces the data byte on the output, MSB first
								// the top bit is already on the pin, so the register goes one place below it
								out_sh_reg[RESULT_W+STATUS_W-2 -: 8] <= cfg_reg;
								out_len_reg <= 5'd16;
								out_cnt_reg <= 5'd8;
								if (ov_seen_reg && !overvoltage)
								begin
									cfg_reg[`CFG_CLAMP] <= 1'b1;
									ov_seen_reg <= 1'b0;
								end
							end
						end
						else
							state_reg <= ST_IDLE;
					end
					else if (state_reg == ST_DATA && bit_cnt_reg == 5'd15)
					begin
						state_reg <= ST_IDLE;
						if (access_reg && !read_reg)
							cfg_reg[4:1] <= cmd_word[4:1];
					end
				end
				if (sck_fall && serial_out_oe)
				begin
					if (out_cnt_reg >= out_len_reg && !daisy_chain_mode)
						serial_out_oe <= 1'b0;
					else
					begin
						// next bit each falling edge, status right after LSB
						serial_out_o <= out_sh_reg[RESULT_W+STATUS_W-2];
						out_sh_reg <= {out_sh_reg[RESULT_W+STATUS_W-2:0], 1'b0};
						out_cnt_reg <= out_cnt_reg + 5'h01;
					end
				end
			end
		end
	end
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_en <= 1'b0;
			span_en <= 1'b0;
			hiz_en <= 1'b0;
			turbo_en <= 1'b0;
			input_clamp_flag <= 1'b1;
		end
		else
		begin
			status_en <= cfg_reg[`CFG_STATUS_EN];
			span_en <= cfg_reg[`CFG_SPAN_EN];
			hiz_en <= cfg_reg[`CFG_HIZ_EN];
			turbo_en <= cfg_reg[`CFG_TURBO_EN];
			input_clamp_flag <= cfg_reg[`CFG_CLAMP];
		end
	end
endmodule

// ---- pkg/adc_cfg_regs.vh ----
// constants for the converter serial interface and configuration register
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH
`define CMD_PATTERN 6'h14
`define CMD_RW_BIT 6
`define CFG_STATUS_EN 4
`define CFG_SPAN_EN 3
`define CFG_HIZ_EN 2
`define CFG_TURBO_EN 1
`define CFG_CLAMP 0
`define CFG_RESET 8'h01
`define CFG_WMASK 8'h1e
`define RESULT_BITS 16
`define STATUS_BITS 6
`define FRAME_BITS 16
`endif

// ---- hw/pin_sync.v ----
// three-stage pin synchroniser with agreement filter
module pin_sync
(
	input wire core_clk,
	input wire rst_n,
	input wire pin,
	output reg level_reg
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	// a change counts only once the second and third stages agree
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			level_reg <= 1'b1;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_reg <= s3_reg;
		end
	end
endmodule

// ---- verif/adc_spi_props.sv ----
// checker: port properties of the converter serial interface
module adc_spi_props
#(
	parameter RESULT_W = 16,
	parameter STATUS_W = 6
)
(
	input wire core_clk,
	input wire reset_n,
	input wire convert_start,
	input wire sck,
	input wire serial_in,
	input wire [RESULT_W-1:0] conv_result,
	input wire overvoltage,
	input wire daisy_chain_mode,
	input wire serial_out_o,
	input wire serial_out_oe,
	input wire status_en,
	input wire span_en,
	input wire hiz_en,
	input wire turbo_en,
	input wire input_clamp_flag
);
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!reset_n);
a_reset_values: assert property ($rose(reset_n) |-> input_clamp_flag && !status_en && !serial_out_oe)
	else $error("reset values");
a_drive_on_select: assert property ($fell(convert_start) |-> ##[3:7] serial_out_oe)
	else $error("no drive");
a_release_deselect: assert property ($rose(convert_start) |-> ##[1:8] !serial_out_oe)
	else $error("no release");
a_out_steady: assert property (sck && $past(sck, 3) && serial_out_oe |-> $stable(serial_out_o))
	else $error("moved while high");
a_cfg_in_frame: assert property ($changed({status_en, span_en, hiz_en, turbo_en}) |-> !convert_start)
	else $error("cfg outside frame");
a_clamp_sticky: assert property (!input_clamp_flag && convert_start |=> !input_clamp_flag)
	else $error("flag cleared");
a_clamp_return: assert property ($rose(input_clamp_flag) |-> !overvoltage && !convert_start)
	else $error("bad clear");
a_ov_sets_flag: assert property (overvoltage |-> ##[1:6] !input_clamp_flag)
	else $error("flag not set");
c_release: cover property ($fell(serial_out_oe) && !convert_start);
c_status: cover property ($rose(status_en));
c_clear: cover property ($rose(input_clamp_flag));
endmodule
bind adc_spi_config_access_status adc_spi_props #(.RESULT_W(RESULT_W), .STATUS_W(STATUS_W)) props (.*);

// ---- verif/spi_host.sv ----
// host model: frames the link with chip select, link clock and command bits
module spi_host
(
	output logic convert_start,
	output logic sck,
	output logic serial_in,
	input wire serial_out_o,
	input wire serial_out_oe
);
timeunit 1ns;
timeprecision 1ps;
wire line = serial_out_oe ? serial_out_o : 1'bz;
initial
begin
	convert_start = 1'b1;
	sck = 1'b0;
	serial_in = 1'b1;
end
// link clock stands still outside frames; bits sampled late in the high phase
// slow link clock: the block samples it, so the minimum rates do not apply here
task automatic frame(input logic [15:0] w, input int n, output logic [21:0] q, output logic oe_end);
	q = 'z;
	convert_start = 1'b0;
	#300;
	for (int i = 0; i < n; i++)
	begin
		#20 serial_in = (i < 16) ? w[15-i] : 1'b1;
		#80 sck = 1'b1;
		#100 q[21-i] = line;
		sck = 1'b0;
	end
	serial_in = 1'b1;
	#300 oe_end = serial_out_oe;
	convert_start = 1'b1;
	#500;
endtask
endmodule

// ---- verif/adc_spi_config_access_status_bench.sv ----
// bench: register access and status readout through the host model
module adc_spi_config_access_status_bench;
timeunit 1ns;
timeprecision 1ps;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; $display("FAIL %0t mismatch", $time); end end
logic core_clk = 1'b0;
logic reset_n = 1'b0;
logic overvoltage = 1'b0;
logic daisy_chain_mode = 1'b0;
logic [21:0] q;
logic oe_end;
logic [4:0] c = 5'h01;
int fails = 0;
int checks_done = 0;
wire convert_start, sck, serial_in, serial_out_o, serial_out_oe, status_en, span_en, hiz_en, turbo_en, input_clamp_flag;
wire [15:0] conv_result = 16'ha5c3;
wire [4:0] cfg = {status_en, span_en, hiz_en, turbo_en, input_clamp_flag};
logic [20:0] rows [7] = '{{16'h14ff, 5'h1f}, {16'h5400, 5'h1f}, {16'h1500, 5'h1f}, {16'h9400, 5'h1f},
	{16'h1410, 5'h11}, {16'h1402, 5'h03}, {16'h5400, 5'h03}};
always #12.5 core_clk = ~core_clk;
adc_spi_config_access_status uut (.*);
spi_host host (.*);
task wrap_up;
	if (fails == 0 && checks_done > 0)
		$display("Regression OK");
	else
		$display("Regression broken");
	$finish;
endtask
task go(input logic [15:0] w, input int n, input logic [4:0] e);
	host.frame(w, n, q, oe_end);
	`CHK(q[21:14], conv_result[15:8])
	`CHK(q[13:6], (w[15:8] == 8'h54 && !daisy_chain_mode) ? {3'h0, c} : conv_result[7:0])
	if (c[4] && n == 22 && !(w[15:8] == 8'h54 && !daisy_chain_mode)) `CHK(q[5:0], {c[0], c[3:1], 2'h0})
	`CHK(oe_end, c[4] && (n < 22 || daisy_chain_mode))
	`CHK(cfg, e)
	c = e;
endtask
initial
begin
	repeat (8) @(posedge core_clk);
	#2 reset_n = 1'b1;
	repeat (8) @(posedge core_clk);
	`CHK({cfg, serial_out_oe}, 6'h02)
	foreach (rows[i]) go(rows[i][20:5], 22, rows[i][4:0]);
	@(posedge core_clk) #2 overvoltage = 1'b1;
	repeat (8) @(posedge core_clk);
	`CHK(input_clamp_flag, 1'b0)
	c[0] = 1'b0;
	go(16'h5400, 16, c); // an active event keeps the flag low
	@(posedge core_clk) #2 overvoltage = 1'b0;
	go(16'h5400, 16, {c[4:1], 1'b1});
	go(16'h1410, 16, 5'h11);
	@(posedge core_clk) #2 daisy_chain_mode = 1'b1;
	go(16'h5400, 22, c);
	@(posedge core_clk) #2 daisy_chain_mode = 1'b0;
	go(16'h1400, 18, 5'h01);
	go(16'h5400, 16, c);
	wrap_up();
end
endmodule
